// [rtl/pcpt_pkg.sv]
// constants and types for the pll clock gate, phase delay and user pattern registers
// ============================================================
package pcpt_pkg;

  // ============================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_GATE_PHASE = 8'h6D;
  localparam logic [7:0] IDX_PAT_A_LO   = 8'h74;
  localparam logic [7:0] IDX_PAT_A_HI   = 8'h75;
  localparam logic [7:0] IDX_PAT_B_LO   = 8'h76;
  localparam logic [7:0] IDX_PAT_B_HI   = 8'h77;
  localparam logic [7:0] IDX_CONFIG     = 8'h80;
  localparam logic [7:0] IDX_STATUS     = 8'h81;

  // ============================================================
  // field positions
  localparam int GATE_BIT    = 5;
  localparam int FCB_HI_BIT  = 4;
  localparam int DLY_LSB     = 1;
  localparam int DLY_W       = 3;
  localparam int FCB_LO_BIT  = 0;
  localparam int NIB_LSB     = 4;
  localparam int CFG_SRC_PLL = 0;
  localparam int CFG_PLL_EN  = 1;
  localparam int CFG_DECIM   = 2;
  localparam int CFG_SEL_LSB = 4;
  localparam int SEL_W       = 3;
  localparam int ST_GATE     = 0;
  localparam int ST_DLY_ACT  = 1;
  localparam int ST_CYC_LSB  = 4;

  // ============================================================
  // reset values and sizes
  localparam logic [7:0] GATE_PHASE_RST = 8'h00;
  localparam logic [7:0] PAT_RST        = 8'h00;
  localparam logic [7:0] CONFIG_RST     = 8'h00;
  localparam logic [7:0] GATE_PHASE_MSK = 8'h3F;
  localparam int         SYNC_STAGES    = 3;
  localparam int         DELAY_DEPTH    = 16;
  localparam int         PAT_W          = 12;

  // ============================================================
  // types
  typedef enum logic [2:0] {
    SEL_CONVERTED = 3'b000,
    SEL_PATTERN_A = 3'b001,
    SEL_PATTERN_B = 3'b010,
    SEL_ALTERNATE = 3'b011
  } pcpt_sel_t;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } pcpt_bus_t;

endpackage

// [rtl/pcpt_delay_line.sv]
// vco cycle delay line for the forwarded pll clock
`timescale 1ns/1ps
module pcpt_delay_line #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic [2:0] delay_code,
  input  wire logic       delay_on,
  // clock stream
  input  wire logic       din,
  output logic            dout
);

  logic [DEPTH-2:0] taps;
  logic [4:0]       cycles;

  // ============================================================
  // code to cycle count
  function automatic logic [4:0] code_cycles(input logic [2:0] code);
    case (code)
      3'h0:    code_cycles = 5'h00;
      3'h1:    code_cycles = 5'h01;
      3'h7:    code_cycles = 5'h0F;
      default: code_cycles = {1'b0, code, 1'b0} + 5'h02;
    endcase
  endfunction

  assign cycles = delay_on ? code_cycles(delay_code) : 5'h00;

  // ============================================================
  // shift register and tap select
  always_ff @(posedge clk) begin
    if (!rstn) begin
      taps <= '0;
    end else begin
      taps <= {taps[DEPTH-3:0], din};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout <= 1'b0;
    end else if (cycles == 5'h00) begin
      dout <= din;
    end else begin
      dout <= taps[cycles[3:0] - 4'h1];
    end
  end

endmodule

// [rtl/pcpt_pattern_mux.sv]
// output word select between converted samples and user patterns
`timescale 1ns/1ps
module pcpt_pattern_mux #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // selection and patterns
  input  wire logic [2:0]   select,
  input  wire logic [W-1:0] pat_a,
  input  wire logic [W-1:0] pat_b,
  // data
  input  wire logic [W-1:0] sample_in,
  output logic [W-1:0]      dout
);

  logic alt_b;

  // ============================================================
  // alternation between a and b word by word
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alt_b <= 1'b0;
    end else if (select == pcpt_pkg::SEL_ALTERNATE) begin
      alt_b <= ~alt_b;
    end else begin
      alt_b <= 1'b0;
    end
  end

  // ============================================================
  // output word
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout <= '0;
    end else begin
      case (select)
        pcpt_pkg::SEL_PATTERN_A: dout <= pat_a;
        pcpt_pkg::SEL_PATTERN_B: dout <= pat_b;
        pcpt_pkg::SEL_ALTERNATE: dout <= alt_b ? pat_b : pat_a;
        default:                 dout <= sample_in;
      endcase
    end
  end

endmodule

// [rtl/pcpt_regs.sv]
// register bank with avalon slave, pll clock gate, phase delay and user patterns
`timescale 1ns/1ps
module pcpt_regs #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic [31:0]            AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // pll clock path
  input  wire logic              PLL_CLK_IN,
  output logic                   CORE_CLK_OUT,
  // converter data path
  input  wire logic [11:0]       SAMPLE_IN,
  output logic [11:0]            SAMPLE_OUT,
  // unused test pins
  output logic [7:0]             UNUSED_TEST_OUT
);

  // ============================================================
  // declarations
  logic [7:0]            gate_phase;
  logic [7:0]            pat_a_lo;
  logic [7:0]            pat_a_hi;
  logic [7:0]            pat_b_lo;
  logic [7:0]            pat_b_hi;
  logic [7:0]            config_reg;
  pcpt_pkg::pcpt_bus_t   bus_state;
  pcpt_pkg::pcpt_bus_t   next_bus_state;
  logic                  take;
  logic                  wr_byte0;
  logic [7:0]            index;
  logic                  index_ok;
  logic [7:0]            rd_byte;
  logic [7:0]            status_byte;
  logic [2:0]            sync_ff;
  logic                  pll_level;
  logic                  pll_mode;
  logic                  gate_on;
  logic                  delay_on;
  logic                  gated_clk;
  logic                  delayed_clk;
  logic [11:0]           pattern_a;
  logic [11:0]           pattern_b;
  logic [11:0]           mux_out;
  logic [2:0]            sel_field;
  logic [2:0]            delay_code;
  logic                  gate_en;
  logic [2:0]            output_clock_vco_delay;
  logic [1:0]            factory_reserved_bits;
  logic                  index_hi_ok;
  logic                  rd_take;
  logic                  wr_gate_phase;
  logic                  wr_pat_a_lo;
  logic                  wr_pat_a_hi;
  logic                  wr_pat_b_lo;
  logic                  wr_pat_b_hi;
  logic                  wr_config;
  logic [2:0]            eff_code;
  logic                  dly_nonzero;
  logic                  pll_agree;
  logic [3:0]            nib_a;
  logic [3:0]            nib_b;
  logic [3:0]            test_nib_a;
  logic [3:0]            test_nib_b;

  // ============================================================
  // address decode
  function automatic logic idx_mapped(input logic [7:0] idx);
    case (idx)
      pcpt_pkg::IDX_GATE_PHASE,
      pcpt_pkg::IDX_PAT_A_LO,
      pcpt_pkg::IDX_PAT_A_HI,
      pcpt_pkg::IDX_PAT_B_LO,
      pcpt_pkg::IDX_PAT_B_HI,
      pcpt_pkg::IDX_CONFIG,
      pcpt_pkg::IDX_STATUS: idx_mapped = 1'b1;
      default:              idx_mapped = 1'b0;
    endcase
  endfunction

  assign index       = AVS_ADDRESS[9:2];
  assign index_hi_ok = ((AVS_ADDRESS >> 10) == '0);
  assign index_ok    = index_hi_ok && idx_mapped(index);
  assign take        = (bus_state == pcpt_pkg::BUS_IDLE) && (AVS_READ || AVS_WRITE);
  assign rd_take     = take && AVS_READ;
  assign wr_byte0    = take && AVS_WRITE && AVS_BYTEENABLE[0] && index_ok;

  // ============================================================
  // per register write strobes
  assign wr_gate_phase = wr_byte0 && (index == pcpt_pkg::IDX_GATE_PHASE);
  assign wr_pat_a_lo   = wr_byte0 && (index == pcpt_pkg::IDX_PAT_A_LO);
  assign wr_pat_a_hi   = wr_byte0 && (index == pcpt_pkg::IDX_PAT_A_HI);
  assign wr_pat_b_lo   = wr_byte0 && (index == pcpt_pkg::IDX_PAT_B_LO);
  assign wr_pat_b_hi   = wr_byte0 && (index == pcpt_pkg::IDX_PAT_B_HI);
  assign wr_config     = wr_byte0 && (index == pcpt_pkg::IDX_CONFIG);

  // ============================================================
  // bus handshake state
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      pcpt_pkg::BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          next_bus_state = pcpt_pkg::BUS_ANSWER;
        end
      end
      pcpt_pkg::BUS_ANSWER: begin
        next_bus_state = pcpt_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = pcpt_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      bus_state <= pcpt_pkg::BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~take;
    end
  end

  // ============================================================
  // pll output gate bit
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      gate_en <= pcpt_pkg::GATE_PHASE_RST[pcpt_pkg::GATE_BIT];
    end else if (wr_gate_phase) begin
      gate_en <= AVS_WRITEDATA[pcpt_pkg::GATE_BIT];
    end
  end

  // ============================================================
  // output clock vco delay code
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      output_clock_vco_delay <= pcpt_pkg::GATE_PHASE_RST[pcpt_pkg::DLY_LSB +: pcpt_pkg::DLY_W];
    end else if (wr_gate_phase) begin
      output_clock_vco_delay <= AVS_WRITEDATA[pcpt_pkg::DLY_LSB +: pcpt_pkg::DLY_W];
    end
  end

  // ============================================================
  // factory reserved bits, stored and read back as written
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      factory_reserved_bits <= {pcpt_pkg::GATE_PHASE_RST[pcpt_pkg::FCB_HI_BIT],
                                pcpt_pkg::GATE_PHASE_RST[pcpt_pkg::FCB_LO_BIT]};
    end else if (wr_gate_phase) begin
      factory_reserved_bits <= {AVS_WRITEDATA[pcpt_pkg::FCB_HI_BIT],
                                AVS_WRITEDATA[pcpt_pkg::FCB_LO_BIT]};
    end
  end

  // ============================================================
  // register image, top two bits have no storage
  always_comb begin
    gate_phase = 8'h00;
    gate_phase[pcpt_pkg::GATE_BIT] = gate_en;
    gate_phase[pcpt_pkg::FCB_HI_BIT] = factory_reserved_bits[1];
    gate_phase[pcpt_pkg::DLY_LSB +: pcpt_pkg::DLY_W] = output_clock_vco_delay;
    gate_phase[pcpt_pkg::FCB_LO_BIT] = factory_reserved_bits[0];
  end

  // ============================================================
  // user pattern registers
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pat_a_lo <= pcpt_pkg::PAT_RST;
    end else if (wr_pat_a_lo) begin
      pat_a_lo <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pat_a_hi <= pcpt_pkg::PAT_RST;
    end else if (wr_pat_a_hi) begin
      pat_a_hi <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pat_b_lo <= pcpt_pkg::PAT_RST;
    end else if (wr_pat_b_lo) begin
      pat_b_lo <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pat_b_hi <= pcpt_pkg::PAT_RST;
    end else if (wr_pat_b_hi) begin
      pat_b_hi <= AVS_WRITEDATA[7:0];
    end
  end

  // ============================================================
  // configuration register
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      config_reg <= pcpt_pkg::CONFIG_RST;
    end else if (wr_config) begin
      config_reg <= AVS_WRITEDATA[7:0];
    end
  end

  // ============================================================
  // read path
  always_comb begin
    eff_code    = delay_on ? delay_code : 3'h0;
    dly_nonzero = (eff_code != 3'h0);
    status_byte = 8'h00;
    status_byte[pcpt_pkg::ST_GATE]    = gate_on;
    status_byte[pcpt_pkg::ST_DLY_ACT] = delay_on;
    status_byte[pcpt_pkg::ST_CYC_LSB] = dly_nonzero;
  end

  always_comb begin
    rd_byte = 8'h00;
    case (index)
      pcpt_pkg::IDX_GATE_PHASE: rd_byte = gate_phase & pcpt_pkg::GATE_PHASE_MSK;
      pcpt_pkg::IDX_PAT_A_LO:   rd_byte = pat_a_lo;
      pcpt_pkg::IDX_PAT_A_HI:   rd_byte = pat_a_hi;
      pcpt_pkg::IDX_PAT_B_LO:   rd_byte = pat_b_lo;
      pcpt_pkg::IDX_PAT_B_HI:   rd_byte = pat_b_hi;
      pcpt_pkg::IDX_CONFIG:     rd_byte = config_reg;
      pcpt_pkg::IDX_STATUS:     rd_byte = status_byte;
      default:                  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (rd_take) begin
      AVS_READDATA <= index_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // ============================================================
  // pll clock input synchroniser
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], PLL_CLK_IN};
    end
  end

  // second and third stage agree: the level has settled
  assign pll_agree = (sync_ff[1] == sync_ff[2]);

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pll_level <= 1'b0;
    end else if (pll_agree) begin
      pll_level <= sync_ff[2];
    end
  end

  // ============================================================
  // gate and delay qualification
  assign pll_mode   = config_reg[pcpt_pkg::CFG_SRC_PLL] &&
                      config_reg[pcpt_pkg::CFG_PLL_EN];
  assign gate_on    = pll_mode && gate_phase[pcpt_pkg::GATE_BIT];
  assign delay_on   = pll_mode && !config_reg[pcpt_pkg::CFG_DECIM];
  assign delay_code = gate_phase[pcpt_pkg::DLY_LSB +: pcpt_pkg::DLY_W];
  assign gated_clk  = pll_mode ? (gate_on & pll_level) : pll_level;

  pcpt_delay_line #(
    .DEPTH (pcpt_pkg::DELAY_DEPTH)
  ) i_pcpt_delay_line (
    .clk        (CORE_CLK),
    .rstn       (RSTN),
    .delay_code (delay_code),
    .delay_on   (delay_on),
    .din        (gated_clk),
    .dout       (delayed_clk)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      CORE_CLK_OUT <= 1'b0;
    end else begin
      CORE_CLK_OUT <= delayed_clk;
    end
  end

  // ============================================================
  // user pattern assembly and output select
  assign nib_a     = pat_a_lo[pcpt_pkg::NIB_LSB +: 4];
  assign nib_b     = pat_b_lo[pcpt_pkg::NIB_LSB +: 4];
  assign pattern_a = {pat_a_hi, nib_a};
  assign pattern_b = {pat_b_hi, nib_b};
  assign sel_field = config_reg[pcpt_pkg::CFG_SEL_LSB +: pcpt_pkg::SEL_W];

  pcpt_pattern_mux #(
    .W (pcpt_pkg::PAT_W)
  ) i_pcpt_pattern_mux (
    .clk       (CORE_CLK),
    .rstn      (RSTN),
    .select    (sel_field),
    .pat_a     (pattern_a),
    .pat_b     (pattern_b),
    .sample_in (SAMPLE_IN),
    .dout      (mux_out)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      SAMPLE_OUT <= 12'h000;
    end else begin
      SAMPLE_OUT <= mux_out;
    end
  end

  // ============================================================
  // unused test pins driven by the low nibbles
  assign test_nib_a = pat_a_lo[pcpt_pkg::NIB_LSB-1:0];
  assign test_nib_b = pat_b_lo[pcpt_pkg::NIB_LSB-1:0];

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      UNUSED_TEST_OUT <= 8'h00;
    end else begin
      UNUSED_TEST_OUT <= {test_nib_b, test_nib_a};
    end
  end

endmodule

// [tb/pcpt_regs_sva.sv]
// assertion checker for the pcpt register bank
`timescale 1ns/1ps
module pcpt_regs_sva #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RSTN,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic [31:0]       AVS_WRITEDATA,
  input wire logic [3:0]        AVS_BYTEENABLE,
  input wire logic [31:0]       AVS_READDATA,
  input wire logic              AVS_WAITREQUEST,
  // clock and data paths
  input wire logic              PLL_CLK_IN,
  input wire logic              CORE_CLK_OUT,
  input wire logic [11:0]       SAMPLE_IN,
  input wire logic [11:0]       SAMPLE_OUT,
  input wire logic [7:0]        UNUSED_TEST_OUT
);
  // ============================================================
  // shadow registers
  logic [7:0]  gp, cfg, alo, ahi, blo, bhi;
  logic [4:0]  q;
  wire logic        wr   = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire logic [7:0]  ix   = AVS_ADDRESS[9:2];
  wire logic        pm   = cfg[0] && cfg[1];
  wire logic [2:0]  sel  = cfg[6:4];
  wire logic [2:0]  code = gp[3:1];
  wire logic [11:0] pa   = {ahi, alo[7:4]};
  wire logic [11:0] pb   = {bhi, blo[7:4]};
  wire logic        ok   = q > 5'h17;
  wire logic        dq   = q > 5'h02 && !AVS_WRITE;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      {gp, cfg, alo, ahi, blo, bhi} <= 48'h0;
    end else if (wr) begin
      case (ix)
        pcpt_pkg::IDX_GATE_PHASE: gp  <= AVS_WRITEDATA[7:0];
        pcpt_pkg::IDX_CONFIG:     cfg <= AVS_WRITEDATA[7:0];
        pcpt_pkg::IDX_PAT_A_LO:   alo <= AVS_WRITEDATA[7:0];
        pcpt_pkg::IDX_PAT_A_HI:   ahi <= AVS_WRITEDATA[7:0];
        pcpt_pkg::IDX_PAT_B_LO:   blo <= AVS_WRITEDATA[7:0];
        pcpt_pkg::IDX_PAT_B_HI:   bhi <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end
  // cycles since the last accepted write
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || wr) q <= 5'h00;
    else if (q != 5'h1F) q <= q + 5'h01;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence fast_s; ##[4:7] CORE_CLK_OUT; endsequence
  sequence slow_s; ##17 !CORE_CLK_OUT ##[2:5] CORE_CLK_OUT; endsequence
  // ============================================================
  // assertions
  gate_block_a: assert property (pm && !gp[5] && ok |-> !CORE_CLK_OUT)
    else $error("blocked clock still forwarded");
  gate_pass_a: assert property ($rose(PLL_CLK_IN) && ok && pm && gp[5] && !cfg[2]
    && code == 3'h0 |-> fast_s) else $error("gated clock not forwarded");
  dly_max_a: assert property ($rose(PLL_CLK_IN) && ok && pm && gp[5] && !cfg[2]
    && code == 3'h7 |-> slow_s) else $error("longest delay wrong");
  not_pll_a: assert property ($rose(PLL_CLK_IN) && ok && !pm |-> fast_s)
    else $error("settings acted outside pll mode");
  decim_nodly_a: assert property ($rose(PLL_CLK_IN) && ok && pm && gp[5] && cfg[2]
    |-> fast_s) else $error("delay acted with decimation");
  rsv_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST
    && ix == pcpt_pkg::IDX_GATE_PHASE |-> AVS_READDATA[7:6] == 2'b00)
    else $error("unused bits read nonzero");
  pat_a_a: assert property (dq && sel == 3'h1 |-> SAMPLE_OUT == pa)
    else $error("pattern a wrong");
  pat_b_a: assert property (dq && sel == 3'h2 |-> SAMPLE_OUT == pb)
    else $error("pattern b wrong");
  samp_pass_a: assert property (dq && sel == 3'h0 |-> SAMPLE_OUT == $past(SAMPLE_IN, 2))
    else $error("samples not passed");
  alt_ab_a: assert property (dq && sel == 3'h3 && SAMPLE_OUT == pa |=> SAMPLE_OUT == pb)
    else $error("alternate order wrong");
endmodule
bind pcpt_regs pcpt_regs_sva #(.ADDR_W(ADDR_W)) i_pcpt_regs_sva (.CORE_CLK, .RSTN,
  .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
  .AVS_WAITREQUEST, .PLL_CLK_IN, .CORE_CLK_OUT, .SAMPLE_IN, .SAMPLE_OUT, .UNUSED_TEST_OUT);

// [tb/pcpt_regs_tb_top.sv]
// testbench for the pcpt register bank
`timescale 1ns/1ps
module pcpt_regs_tb_top;
  logic        CORE_CLK, RSTN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic        PLL_CLK_IN, CORE_CLK_OUT;
  logic [9:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [11:0] SAMPLE_IN, SAMPLE_OUT;
  logic [7:0]  UNUSED_TEST_OUT;
  int          failures;
  int          n_tests;
  // pin to output: three sync stages, agreement, delay and output flops
  localparam int BASE_LAT = 7;
  int          dt [8] = '{0, 1, 6, 8, 10, 12, 14, 15};
  pcpt_regs #(.ADDR_W(10)) i_pcpt_regs (.CORE_CLK, .RSTN, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .PLL_CLK_IN, .CORE_CLK_OUT, .SAMPLE_IN, .SAMPLE_OUT, .UNUSED_TEST_OUT);
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  // ============================================================
  // shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] ix, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    AVS_ADDRESS <= {ix, 2'b00};
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0);
    r = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    chk(12'(n), 12'h002);
    @(posedge CORE_CLK);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, ix, d, r);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    logic [7:0] r;
    acc(1'b0, ix, 8'h00, r);
    chk({4'h0, r}, {4'h0, e});
  endtask
  task automatic lat(output int c);
    PLL_CLK_IN <= 1'b1;
    c = 0;
    do begin
      @(posedge CORE_CLK);
      c++;
    end while (CORE_CLK_OUT !== 1'b1 && c < 40);
    PLL_CLK_IN <= 1'b0;
    repeat (40) @(posedge CORE_CLK);
  endtask
  task automatic cc(input logic [7:0] g, input logic [7:0] c, input int e);
    int n;
    wr(pcpt_pkg::IDX_GATE_PHASE, g);
    wr(pcpt_pkg::IDX_CONFIG, c);
    repeat (30) @(posedge CORE_CLK);
    lat(n);
    if (e >= 0) chk(12'(n), 12'(e));
  endtask
  // ============================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] ix [7] = '{8'h6D, 8'h74, 8'h75, 8'h76, 8'h77, 8'h80, 8'h10};
    foreach (ix[i]) rd(ix[i], 8'h00);
    chk({4'h0, UNUSED_TEST_OUT}, 12'h000);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(pcpt_pkg::IDX_GATE_PHASE, 8'hEE);
    rd(pcpt_pkg::IDX_GATE_PHASE, 8'h2E);
    AVS_BYTEENABLE <= 4'h0;
    wr(pcpt_pkg::IDX_PAT_A_LO, 8'hB0);
    AVS_BYTEENABLE <= 4'hF;
    rd(pcpt_pkg::IDX_PAT_A_LO, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pattern();
    logic [11:0] o1;
    wr(pcpt_pkg::IDX_PAT_A_LO, 8'hA0);
    wr(pcpt_pkg::IDX_PAT_A_HI, 8'h5C);
    rd(pcpt_pkg::IDX_PAT_A_HI, 8'h5C);
    wr(pcpt_pkg::IDX_PAT_B_LO, 8'h30);
    wr(pcpt_pkg::IDX_PAT_B_HI, 8'hC3);
    chk({4'h0, UNUSED_TEST_OUT}, 12'h000);
    wr(pcpt_pkg::IDX_CONFIG, 8'h10);
    repeat (4) @(posedge CORE_CLK);
    chk(SAMPLE_OUT, 12'h5CA);
    wr(pcpt_pkg::IDX_CONFIG, 8'h20);
    repeat (4) @(posedge CORE_CLK);
    chk(SAMPLE_OUT, 12'hC33);
    wr(pcpt_pkg::IDX_CONFIG, 8'h30);
    repeat (4) @(posedge CORE_CLK);
    o1 = SAMPLE_OUT;
    @(posedge CORE_CLK);
    chk(SAMPLE_OUT, (o1 === 12'h5CA) ? 12'hC33 : 12'h5CA);
    chk(o1 ^ SAMPLE_OUT, 12'h5CA ^ 12'hC33);
    SAMPLE_IN <= 12'h123;
    wr(pcpt_pkg::IDX_CONFIG, 8'h00);
    repeat (4) @(posedge CORE_CLK);
    chk(SAMPLE_OUT, 12'h123);
    $display("test pattern done");
  endtask
  task automatic t_clock();
    cc(8'h00, 8'h00, BASE_LAT);
    for (int k = 0; k < 8; k++) cc(8'h20 | 8'(k << 1), 8'h03, BASE_LAT + dt[k]);
    rd(pcpt_pkg::IDX_STATUS, 8'h13);
    cc(8'h00, 8'h03, 40);
    cc(8'h2E, 8'h07, BASE_LAT);
    rd(pcpt_pkg::IDX_STATUS, 8'h01);
    cc(8'h0E, 8'h01, BASE_LAT);
    cc(8'h0E, 8'h02, BASE_LAT);
    $display("test clock done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    failures = 0;
    n_tests = 0;
    RSTN = 1'b0;
    AVS_ADDRESS = 10'h000;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h00000000;
    AVS_BYTEENABLE = 4'hF;
    PLL_CLK_IN = 1'b0;
    SAMPLE_IN = 12'h000;
    repeat (5) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    t_reset();
    t_regs();
    t_pattern();
    t_clock();
    give_verdict();
  end
endmodule
